/* File: dv/sbrmp_chk.sv */
// bus and mp-bit assertions of the rate block
`timescale 1ns/100ps
module sbrmp_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_active,
  input wire logic        tx_mp_bit
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read upper bits set");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  tx_idle_a: assert property (!tx_active |=> !tx_mp_bit)
    else $error("mp bit sent while idle");
  tx_cause_a: assert property ($rose(tx_mp_bit) |-> $past(tx_active))
    else $error("mp bit without transmission");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (tx_mp_bit);
endmodule : sbrmp_chk

/* File: dv/sbrmp_peer.sv */
// serial peer: received characters and sub-clock ticks
`timescale 1ns/100ps
module sbrmp_peer (
  input  wire logic aclk,
  input  wire logic go,
  input  wire logic mp_in,
  output logic      rx_char_done,
  output logic      rx_mp_bit,
  output logic      subclk_tick
);
  logic [1:0] sub_cnt_r = 2'h0;
  initial rx_char_done = 1'b0;
  initial rx_mp_bit = 1'b0;
  initial subclk_tick = 1'b0;
  always @(posedge aclk) begin
    sub_cnt_r    <= sub_cnt_r + 2'h1;
    subclk_tick  <= (sub_cnt_r == 2'h3);
    rx_char_done <= go;
    // mp bit only means something with its strobe
    rx_mp_bit    <= go ? mp_in : ~rx_mp_bit;
  end
endmodule : sbrmp_peer

/* File: dv/testbench.sv */
// self-checking bench of the rate and mp-bit block
`timescale 1ns/100ps
module testbench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, div_m;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, low_power_hold, sub_mode, subclk_tick, rx_char_done;
  logic        rx_mp_bit, tx_active, rate_tick, bit_tick, tx_mp_bit, go, mp_in, rxf_m, txv_m;
  logic [4:0]  mode_m;
  int          fails, checks;
  sbrmp_top DUT (.*);
  sbrmp_peer peer (.*);
  always #5 aclk = ~aclk;
  task automatic conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wm(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    chk("bresp", s_axi_bresp, a > 8'h08 ? 2'h2 : 2'h0);
    s_axi_bready <= 1'b0;
    if (s[0] && a == 8'h00) div_m = d;
    if (s[0] && a == 8'h04) mode_m = d[4:0];
    if (s[0] && a == 8'h08) txv_m = d[0];
    if (i == 50) fails++;
    if (i == 50) conclude();
    @(posedge aclk);
  endtask : wm
  task automatic rc(input logic [7:0] a);
    int i;
    logic [31:0] e;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    e = 32'h0;
    if (a == 8'h00) e[7:0] = div_m;
    if (a == 8'h04) e[4:0] = mode_m;
    if (a == 8'h08) e[1:0] = {rxf_m, txv_m};
    chk("rdata", s_axi_rdata, e);
    chk("rresp", s_axi_rresp, a > 8'h08 ? 2'h2 : 2'h0);
    s_axi_rready <= 1'b0;
    if (i == 50) fails++;
    if (i == 50) conclude();
    @(posedge aclk);
  endtask : rc
  // cycles between the second and third tick seen
  task automatic per(input bit b, output int n);
    int i, k;
    for (k = 0; k < 3; k++) begin
      n = 0;
      for (i = 0; i < 5000; i++) begin
        @(posedge aclk);
        n++;
        if ((b ? bit_tick : rate_tick) === 1'b1) break;
      end
      if (i == 5000) fails++;
      if (i == 5000) conclude();
    end
  endtask : per
  task automatic send(input logic m);
    go <= 1'b1;
    mp_in <= m;
    @(posedge aclk);
    go <= 1'b0;
    repeat (3) @(posedge aclk);
    if (mode_m[4:2] == 3'b110) rxf_m = m;
  endtask : send
  initial begin
    int n, k, nd;
    int pre[5];
    logic [7:0] tm[4];
    pre = '{1, 8, 16, 64, 4};
    tm = '{8'h08, 8'h0c, 8'h00, 8'h08};
    {aclk, aresetn, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_awvalid,
     s_axi_wvalid, s_axi_wdata, s_axi_wstrb, s_axi_bready, s_axi_arvalid, s_axi_rready,
     low_power_hold, sub_mode, tx_active, go, mp_in, mode_m, rxf_m, txv_m} = '0;
    {fails, checks} = '0;
    div_m = 8'hff;
    void'($urandom(19));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (k = 0; k < 16; k += 4) rc(k[7:0]);
    wm(8'h10, 8'h5a, 4'h1);
    nd = $urandom_range(0, 255);
    wm(8'h00, nd[7:0], 4'hf);
    rc(8'h00);
    wm(8'h00, 8'h33, 4'h0);
    rc(8'h00);
    wm(8'h08, 8'h03, 4'h1);
    rc(8'h08);
    // every prescale and divisor chosen gives an exact rate, no deviation
    for (k = 0; k < 5; k++) begin
      nd = $urandom_range(0, 3);
      sub_mode <= (k == 4);
      wm(8'h04, k == 4 ? 8'h01 : k[7:0], 4'h1);
      wm(8'h00, nd[7:0], 4'h1);
      per(1'b0, n);
      chk("rate", n, pre[k] * (nd + 1));
    end
    sub_mode <= 1'b0;
    wm(8'h00, 8'h00, 4'h1);
    for (k = 0; k < 2; k++) begin
      wm(8'h04, k[7:0] << 2, 4'h1);
      per(1'b1, n);
      chk("bit", n, k ? 8 : 64);
    end
    wm(8'h04, 8'h18, 4'h1);
    send(1'b1);
    rc(8'h08);
    wm(8'h04, 8'h08, 4'h1);
    send(1'b0);
    rc(8'h08);
    wm(8'h08, 8'h01, 4'h1);
    for (k = 0; k < 4; k++) begin
      wm(8'h04, tm[k], 4'h1);
      tx_active <= (k != 3);
      repeat (3) @(posedge aclk);
      chk("txmp", tx_mp_bit, k == 0);
    end
    tx_active <= 1'b0;
    wm(8'h00, 8'h12, 4'h1);
    low_power_hold <= 1'b1;
    repeat (2) @(posedge aclk);
    low_power_hold <= 1'b0;
    div_m = 8'hff;
    rc(8'h00);
    conclude();
  end
endmodule : testbench
bind sbrmp_top sbrmp_chk chk_i (.*);

/* File: shared/sbrmp_pkg.sv */
// types of the bit-rate and mp-bit block
package sbrmp_pkg;

  typedef enum logic [1:0] {
    SBRMP_CLK_SYS,
    SBRMP_CLK_SUB,
    SBRMP_CLK_DIV16,
    SBRMP_CLK_DIV64
  } sbrmp_clk_sel_t;

  typedef struct packed {
    logic [5:0] pre_cnt;
    logic       sub_half;
    logic [7:0] down_cnt;
    logic       rate_tick;
  } sbrmp_gen_t;

  typedef struct packed {
    logic       aw_got;
    logic [7:0] awaddr;
    logic       w_got;
    logic [7:0] wdata;
    logic       wlane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] divisor;
    logic [4:0] mode;
    logic       rx_mp_flag;
    logic       tx_mp_value;
    logic       restart;
    logic [5:0] post_cnt;
    logic       bit_tick;
    logic       tx_mp_out;
  } sbrmp_state_t;

endpackage : sbrmp_pkg

/* File: shared/sbrmp_regs.svh */
// register map, field positions, reset values and counts of the bit-rate and mp-bit block
// Behaviour
// - async multiprocessor reception stores each received mp bit in status bit 1
// - received mp flag is read-only, ignores writes, resets to 0
// - clearing receive enable in mp format keeps the received mp flag
// - async transmission sends the tx mp value bit 0; reset value 0
// - tx mp value is ignored in sync mode, mp disabled, or when idle
// - 8-bit divisor sets bit rate from clock chosen by two select bits
// - divisor is readable and writable at any time
// - divisor becomes all ones on reset, standby, module standby or watch entry
// - async rate is clock over 64 times 4^n times divisor plus one
// - select 00 system, 01 sub-clock, 10 system/16, 11 system/64
// - select 01 uses sub-clock halved when active, undivided in sub modes
// - n=0 and divisor 0 give the highest rate, clock over 64
// - sync rate is clock over 8 times 4^n times divisor plus one
// - clearing receive enable keeps receive state unchanged
`ifndef SBRMP_REGS_SVH
`define SBRMP_REGS_SVH

`define SBRMP_ADDR_W        8
`define SBRMP_OFF_DIVISOR   8'h00
`define SBRMP_OFF_MODE      8'h04
`define SBRMP_OFF_MPBITS    8'h08

`define SBRMP_DIVISOR_RST   8'hff
`define SBRMP_MODE_RST      5'h00

`define SBRMP_MODE_SEL_LO   0
`define SBRMP_MODE_SEL_HI   1
`define SBRMP_MODE_SYNC     2
`define SBRMP_MODE_MP_EN    3
`define SBRMP_MODE_RX_EN    4

`define SBRMP_MP_TX_BIT     0
`define SBRMP_MP_RX_BIT     1

`define SBRMP_PRE_DIV16     6'h0f
`define SBRMP_PRE_DIV64     6'h3f
`define SBRMP_POST_ASYNC    6'h3f
`define SBRMP_POST_SYNC     6'h07

`define SBRMP_RESP_OKAY     2'h0
`define SBRMP_RESP_SLVERR   2'h2

`endif

/* File: src/sbrmp_rate_gen.sv */
// prescaler and down-counting divisor of the bit-rate generator
`timescale 1ns/100ps
`include "sbrmp_regs.svh"

module sbrmp_rate_gen (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] clk_sel,
  input  wire logic       sub_mode,
  input  wire logic       subclk_tick,
  input  wire logic [7:0] divisor,
  input  wire logic       restart,
  output logic            rate_tick
);

  sbrmp_pkg::sbrmp_gen_t s_r;
  sbrmp_pkg::sbrmp_gen_t s_nxt;
  logic                  in_tick;

  always_comb begin
    s_nxt           = s_r;
    s_nxt.rate_tick = 1'b0;
    in_tick         = 1'b0;
    s_nxt.pre_cnt   = s_r.pre_cnt + 6'h01;
    if (subclk_tick) begin
      s_nxt.sub_half = ~s_r.sub_half;
    end
    case (sbrmp_pkg::sbrmp_clk_sel_t'(clk_sel))
      sbrmp_pkg::SBRMP_CLK_SYS: begin
        in_tick = 1'b1;
      end
      sbrmp_pkg::SBRMP_CLK_SUB: begin
        in_tick = subclk_tick & (sub_mode | s_r.sub_half);
      end
      sbrmp_pkg::SBRMP_CLK_DIV16: begin
        in_tick = (s_r.pre_cnt[3:0] == `SBRMP_PRE_DIV16);
      end
      sbrmp_pkg::SBRMP_CLK_DIV64: begin
        in_tick = (s_r.pre_cnt == `SBRMP_PRE_DIV64);
      end
      default: begin
        in_tick = 1'b0;
      end
    endcase
    if (restart) begin
      s_nxt.down_cnt = divisor;
      s_nxt.pre_cnt  = 6'h00;
    end else if (in_tick) begin
      if (s_r.down_cnt == 8'h00) begin
        s_nxt.down_cnt  = divisor;
        s_nxt.rate_tick = 1'b1;
      end else begin
        s_nxt.down_cnt = s_r.down_cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '{pre_cnt: 6'h00, sub_half: 1'b0, down_cnt: `SBRMP_DIVISOR_RST, rate_tick: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rate_tick = s_r.rate_tick;

endmodule : sbrmp_rate_gen

/* File: src/sbrmp_top.sv */
// bit-rate generator and multiprocessor-bit registers behind an axi4-lite slave
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "sbrmp_regs.svh"

module sbrmp_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        low_power_hold,
  input  wire logic        sub_mode,
  input  wire logic        subclk_tick,
  input  wire logic        rx_char_done,
  input  wire logic        rx_mp_bit,
  input  wire logic        tx_active,
  output logic             rate_tick,
  output logic             bit_tick,
  output logic             tx_mp_bit
);

  sbrmp_pkg::sbrmp_state_t s_r;
  sbrmp_pkg::sbrmp_state_t s_nxt;

  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic       wr_go;
  logic       wr_hit;
  logic       rd_hit;
  logic [7:0] rd_val;
  logic       async_mp;
  logic [5:0] post_top;

  // write channels are taken separately, held until the response is gone
  assign s_axi_awready = ~s_r.aw_got & ~s_r.bvalid;
  assign s_axi_wready  = ~s_r.w_got & ~s_r.bvalid;
  assign s_axi_arready = ~s_r.rvalid;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign wr_go   = s_r.aw_got & s_r.w_got;

  assign async_mp = ~s_r.mode[`SBRMP_MODE_SYNC] & s_r.mode[`SBRMP_MODE_MP_EN];

  // async divides each rate tick by 64
  // sync divides each rate tick by 8
  assign post_top = s_r.mode[`SBRMP_MODE_SYNC] ? `SBRMP_POST_SYNC : `SBRMP_POST_ASYNC;

  always_comb begin
    wr_hit = 1'b1;
    case (s_r.awaddr)
      `SBRMP_OFF_DIVISOR: begin
        wr_hit = 1'b1;
      end
      `SBRMP_OFF_MODE: begin
        wr_hit = 1'b1;
      end
      `SBRMP_OFF_MPBITS: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    case (s_axi_araddr)
      `SBRMP_OFF_DIVISOR: begin
        rd_val = s_r.divisor;
      end
      `SBRMP_OFF_MODE: begin
        rd_val = {3'h0, s_r.mode};
      end
      `SBRMP_OFF_MPBITS: begin
        rd_val = {6'h00, s_r.rx_mp_flag, s_r.tx_mp_value};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_nxt          = s_r;
    s_nxt.restart  = 1'b0;
    s_nxt.bit_tick = 1'b0;

    if (aw_take) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (w_take) begin
      s_nxt.w_got  = 1'b1;
      s_nxt.wdata  = s_axi_wdata[7:0];
      s_nxt.wlane0 = s_axi_wstrb[0];
    end

    if (wr_go) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = wr_hit ? `SBRMP_RESP_OKAY : `SBRMP_RESP_SLVERR;
      if (wr_hit && s_r.wlane0) begin
        case (s_r.awaddr)
          `SBRMP_OFF_DIVISOR: begin
            s_nxt.divisor = s_r.wdata;
            s_nxt.restart = 1'b1;
          end
          // receive enable only stores its bit
          `SBRMP_OFF_MODE: begin
            s_nxt.mode = s_r.wdata[4:0];
          end
          // only the transmit bit is writable
          `SBRMP_OFF_MPBITS: begin
            s_nxt.tx_mp_value = s_r.wdata[`SBRMP_MP_TX_BIT];
          end
          default: begin
            s_nxt.restart = 1'b0;
          end
        endcase
      end
    end else if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    if (ar_take) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd_val;
      s_nxt.rresp  = rd_hit ? `SBRMP_RESP_OKAY : `SBRMP_RESP_SLVERR;
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // low-power entry forces divisor to all ones
    if (low_power_hold) begin
      s_nxt.divisor = `SBRMP_DIVISOR_RST;
      s_nxt.restart = 1'b1;
    end

    // clearing receive enable keeps the flag
    if (rx_char_done && async_mp && s_r.mode[`SBRMP_MODE_RX_EN]) begin
      s_nxt.rx_mp_flag = rx_mp_bit;
    end

    // rate tick every cycle at n=0, divisor 0
    if (s_r.restart) begin
      s_nxt.post_cnt = 6'h00;
    end else if (rate_tick) begin
      if (s_r.post_cnt >= post_top) begin
        s_nxt.post_cnt = 6'h00;
        s_nxt.bit_tick = 1'b1;
      end else begin
        s_nxt.post_cnt = s_r.post_cnt + 6'h01;
      end
    end

    // ignored in sync, mp off, or idle
    s_nxt.tx_mp_out = async_mp & tx_active & s_r.tx_mp_value;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '{
        aw_got:      1'b0,
        awaddr:      8'h00,
        w_got:       1'b0,
        wdata:       8'h00,
        wlane0:      1'b0,
        bvalid:      1'b0,
        bresp:       `SBRMP_RESP_OKAY,
        rvalid:      1'b0,
        rdata:       8'h00,
        rresp:       `SBRMP_RESP_OKAY,
        divisor:     `SBRMP_DIVISOR_RST,
        mode:        `SBRMP_MODE_RST,
        rx_mp_flag:  1'b0,
        tx_mp_value: 1'b0,
        restart:     1'b0,
        post_cnt:    6'h00,
        bit_tick:    1'b0,
        tx_mp_out:   1'b0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  sbrmp_rate_gen u_rate_gen (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .clk_sel     (s_r.mode[`SBRMP_MODE_SEL_HI:`SBRMP_MODE_SEL_LO]),
    .sub_mode    (sub_mode),
    .subclk_tick (subclk_tick),
    .divisor     (s_r.divisor),
    .restart     (s_r.restart),
    .rate_tick   (rate_tick)
  );

  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp  = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata  = {24'h000000, s_r.rdata};
  assign s_axi_rresp  = s_r.rresp;
  assign bit_tick     = s_r.bit_tick;
  assign tx_mp_bit    = s_r.tx_mp_out;

endmodule : sbrmp_top
